// ===== adc_status_register_map.sv
`timescale 1ns/1ps
// register bank of a dual converter monitor behind the dynamic configuration port
module adc_status_register_map
	import monitor_regs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fabric side of the configuration port
	input wire port_req_t fabric_req,
	output logic [15:0] fabric_rdata,
	output logic fabric_ready,
	// jtag side of the configuration port
	input wire port_req_t jtag_req,
	output logic [15:0] jtag_rdata,
	output logic jtag_ready,
	// conversion results and calibration from the converter
	input wire result_t conv_result,
	input wire coeff_t coeff_update
);
	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic is_status(input logic [6:0] a);
		return a <= STATUS_LAST;
	endfunction

	function automatic logic [15:0] left_align(input logic [11:0] code);
		return {code, LOW_PAD};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// arbitration between fabric and jtag

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_DONE = 2'b10
	} arb_state_t;

	arb_state_t state_ff;
	arb_state_t nxt_state;
	logic owner_jtag_ff;
	logic last_jtag_ff;
	port_req_t cur_ff;
	logic fabric_pend_ff;
	logic jtag_pend_ff;
	port_req_t fabric_hold_ff;
	port_req_t jtag_hold_ff;
	logic grant_jtag;
	logic grant_any;

	// requests latched so an en pulse is never lost while the other side owns the port
	always_ff @(posedge clk) begin
		if (rst) begin
			fabric_pend_ff <= 1'b0;
			fabric_hold_ff <= '0;
		end else if (fabric_req.en) begin
			fabric_pend_ff <= 1'b1;
			fabric_hold_ff <= fabric_req;
		end else if (grant_any && !grant_jtag) begin
			fabric_pend_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			jtag_pend_ff <= 1'b0;
			jtag_hold_ff <= '0;
		end else if (jtag_req.en) begin
			jtag_pend_ff <= 1'b1;
			jtag_hold_ff <= jtag_req;
		end else if (grant_any && grant_jtag) begin
			jtag_pend_ff <= 1'b0;
		end
	end

	// round robin so neither source starves the other
	always_comb begin
		grant_any = (state_ff == ST_IDLE) && (fabric_pend_ff || jtag_pend_ff);
		if (fabric_pend_ff && jtag_pend_ff) begin
			grant_jtag = !last_jtag_ff;
		end else begin
			grant_jtag = jtag_pend_ff;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (grant_any) begin
					nxt_state = ST_READ;
				end
			end
			ST_READ: begin
				nxt_state = ST_DONE;
			end
			ST_DONE: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur_ff <= '0;
			owner_jtag_ff <= 1'b0;
			last_jtag_ff <= 1'b0;
		end else if (grant_any) begin
			cur_ff <= grant_jtag ? jtag_hold_ff : fabric_hold_ff;
			owner_jtag_ff <= grant_jtag;
			last_jtag_ff <= grant_jtag;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status registers

	logic [15:0] status_ff [0:31];
	logic [15:0] coeff_ff [0:2];
	logic [15:0] peak_ff [0:3];
	logic [15:0] lowest_temp_ff;
	logic [15:0] new_value;

	assign new_value = left_align(conv_result.code);

	// results only come from the converter; port writes never reach here
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 32; i++) begin
				status_ff[i] <= UNUSED_READ;
			end
		end else if (conv_result.valid) begin
			status_ff[conv_result.channel] <= new_value;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 3; i++) begin
				coeff_ff[i] <= UNUSED_READ;
			end
		end else if (coeff_update.valid && coeff_update.index != 2'd3) begin
			coeff_ff[coeff_update.index] <= coeff_update.value;
		end
	end

	// sensor channel for each peak slot: temperature, core, auxiliary, block memory
	function automatic logic [4:0] peak_channel(input int k);
		case (k)
			0: return TEMPERATURE_RESULT[4:0];
			1: return CORE_SUPPLY_RESULT[4:0];
			2: return AUX_SUPPLY_RESULT[4:0];
			default: return BLOCK_MEMORY_SUPPLY_RESULT[4:0];
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int k = 0; k < 4; k++) begin
				peak_ff[k] <= PEAK_RESET;
			end
		end else if (conv_result.valid) begin
			for (int k = 0; k < 4; k++) begin
				if (conv_result.channel == peak_channel(k) && new_value > peak_ff[k]) begin
					peak_ff[k] <= new_value;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lowest_temp_ff <= LOWEST_RESET;
		end else if (conv_result.valid && conv_result.channel == TEMPERATURE_RESULT[4:0]
				&& new_value < lowest_temp_ff) begin
			lowest_temp_ff <= new_value;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers

	logic ctrl_wr;
	logic [15:0] ctrl_rdata;

	// writes below 40h fall through here and are simply dropped
	assign ctrl_wr = (state_ff == ST_READ) && cur_ff.we && !is_status(cur_ff.addr);

	control_store u_control_store (
		.clk(clk),
		.wr_en(ctrl_wr),
		.wr_addr(cur_ff.addr[5:0]),
		.wr_data(cur_ff.wdata),
		.rd_addr(cur_ff.addr[5:0]),
		.rd_data(ctrl_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// read decode

	logic [15:0] status_rdata_ff;
	logic [15:0] read_value;

	always_ff @(posedge clk) begin
		if (rst) begin
			status_rdata_ff <= UNUSED_READ;
		end else if (state_ff == ST_READ) begin
			if (cur_ff.addr < PEAK_TEMPERATURE) begin
				case (cur_ff.addr)
					SUPPLY_OFFSET_COEFF_A: status_rdata_ff <= coeff_ff[0];
					CONVERTER_OFFSET_COEFF_A: status_rdata_ff <= coeff_ff[1];
					CONVERTER_GAIN_COEFF_A: status_rdata_ff <= coeff_ff[2];
					UNUSED_LOCATION_A, UNUSED_LOCATION_B, UNUSED_LOCATION_C: status_rdata_ff <= UNUSED_READ;
					default: status_rdata_ff <= status_ff[cur_ff.addr[4:0]];
				endcase
			end else if (cur_ff.addr <= PEAK_BLOCK_MEMORY_SUPPLY) begin
				status_rdata_ff <= peak_ff[cur_ff.addr[1:0]];
			end else if (cur_ff.addr == LOWEST_TEMPERATURE) begin
				status_rdata_ff <= lowest_temp_ff;
			end else begin
				status_rdata_ff <= UNUSED_READ;
			end
		end
	end

	logic status_sel_ff;

	always_ff @(posedge clk) begin
		if (rst) begin
			status_sel_ff <= 1'b1;
		end else if (state_ff == ST_READ) begin
			status_sel_ff <= is_status(cur_ff.addr);
		end
	end

	assign read_value = status_sel_ff ? status_rdata_ff : ctrl_rdata;

	////////////////////////////////////////////////////////////////////////
	// answers, one-cycle ready to the owning side

	always_ff @(posedge clk) begin
		if (rst) begin
			fabric_ready <= 1'b0;
			jtag_ready <= 1'b0;
			fabric_rdata <= CONTROL_RESET;
			jtag_rdata <= CONTROL_RESET;
		end else begin
			fabric_ready <= (state_ff == ST_DONE) && !owner_jtag_ff;
			jtag_ready <= (state_ff == ST_DONE) && owner_jtag_ff;
			if (state_ff == ST_DONE && !owner_jtag_ff) begin
				fabric_rdata <= read_value;
			end
			if (state_ff == ST_DONE && owner_jtag_ff) begin
				jtag_rdata <= read_value;
			end
		end
	end
endmodule

// ===== monitor_regs_pkg.sv
// shared constants and types for the monitor register bank
package monitor_regs_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam int RESULT_W = 12;
	localparam int NUM_REGS = 128;
	localparam logic [6:0] STATUS_LAST = 7'h3F;
	localparam logic [6:0] CONTROL_FIRST = 7'h40;
	localparam logic [6:0] TEMPERATURE_RESULT = 7'h00;
	localparam logic [6:0] CORE_SUPPLY_RESULT = 7'h01;
	localparam logic [6:0] AUX_SUPPLY_RESULT = 7'h02;
	localparam logic [6:0] DEDICATED_INPUT_RESULT = 7'h03;
	localparam logic [6:0] POS_REFERENCE_RESULT = 7'h04;
	localparam logic [6:0] NEG_REFERENCE_RESULT = 7'h05;
	localparam logic [6:0] BLOCK_MEMORY_SUPPLY_RESULT = 7'h06;
	localparam logic [6:0] UNUSED_LOCATION_A = 7'h07;
	localparam logic [6:0] SUPPLY_OFFSET_COEFF_A = 7'h08;
	localparam logic [6:0] CONVERTER_OFFSET_COEFF_A = 7'h09;
	localparam logic [6:0] CONVERTER_GAIN_COEFF_A = 7'h0A;
	localparam logic [6:0] UNUSED_LOCATION_B = 7'h0B;
	localparam logic [6:0] UNUSED_LOCATION_C = 7'h0C;
	localparam logic [6:0] HOST_CORE_SUPPLY_RESULT = 7'h0D;
	localparam logic [6:0] HOST_AUX_SUPPLY_RESULT = 7'h0E;
	localparam logic [6:0] HOST_MEMORY_IO_SUPPLY_RESULT = 7'h0F;
	localparam logic [6:0] AUXILIARY_INPUT_RESULTS = 7'h10;
	localparam logic [6:0] PEAK_TEMPERATURE = 7'h20;
	localparam logic [6:0] PEAK_CORE_SUPPLY = 7'h21;
	localparam logic [6:0] PEAK_AUX_SUPPLY = 7'h22;
	localparam logic [6:0] PEAK_BLOCK_MEMORY_SUPPLY = 7'h23;
	localparam logic [6:0] LOWEST_TEMPERATURE = 7'h24;
	localparam logic [15:0] PEAK_RESET = 16'h0000;
	localparam logic [15:0] LOWEST_RESET = 16'hFFFF;
	localparam logic [15:0] UNUSED_READ = 16'h0000;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [3:0] LOW_PAD = 4'h0;

	typedef struct packed {
		logic en;
		logic we;
		logic [6:0] addr;
		logic [15:0] wdata;
	} port_req_t;

	typedef struct packed {
		logic valid;
		logic [4:0] channel;
		logic [11:0] code;
	} result_t;

	typedef struct packed {
		logic valid;
		logic [1:0] index;
		logic [15:0] value;
	} coeff_t;
endpackage

// ===== control_store.sv
`timescale 1ns/1ps
// 64-word control memory with registered read data
module control_store
	import monitor_regs_pkg::*;
(
	// clock
	input wire logic clk,
	// access
	input wire logic wr_en,
	input wire logic [5:0] wr_addr,
	input wire logic [15:0] wr_data,
	input wire logic [5:0] rd_addr,
	output logic [15:0] rd_data
);
	logic [15:0] mem [0:63];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule

// ===== port_master.sv
// request master standing for fabric logic or the test access path
`timescale 1ns/1ps
module port_master
	import monitor_regs_pkg::*;
(
	// clock
	input wire logic clk,
	// command from the bench
	input wire logic go,
	input wire port_req_t cmd,
	// configuration port side
	output port_req_t req,
	input wire logic ready,
	output logic busy
);
	initial begin
		req = '0;
		busy = 1'b0;
	end
	// one outstanding request, en pulsed for a single cycle
	always @(posedge go) begin
		busy = 1'b1;
		@(negedge clk);
		req = cmd;
		@(negedge clk);
		// released lines show junk, not the old value
		req = ~cmd;
		req.en = 1'b0;
		@(posedge ready);
		busy = 1'b0;
	end
endmodule

// ===== adc_status_register_map_assertions.sv
// port timing checks for the monitor register bank
`timescale 1ns/1ps
module adc_status_register_map_assertions
	import monitor_regs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// configuration port
	input wire port_req_t fabric_req,
	input wire logic [15:0] fabric_rdata,
	input wire logic fabric_ready,
	input wire port_req_t jtag_req,
	input wire logic [15:0] jtag_rdata,
	input wire logic jtag_ready,
	// converter side
	input wire result_t conv_result,
	input wire coeff_t coeff_update
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// one earlier contender adds three cycles at most
	sequence f_answer;
		##[4:7] fabric_ready;
	endsequence
	sequence j_unused_read;
		jtag_req.en && !jtag_req.we && jtag_req.addr == UNUSED_LOCATION_A;
	endsequence
	sequence f_status_write;
		fabric_req.en && fabric_req.we && fabric_req.addr <= STATUS_LAST;
	endsequence
	a_fab_answer_time: assert property (fabric_req.en |-> f_answer) else $error("fabric answer late");
	a_jtag_answer_time: assert property (jtag_req.en |-> ##[4:7] jtag_ready) else $error("jtag answer late");
	a_fab_ready_pulse: assert property (fabric_ready |=> !fabric_ready) else $error("fabric ready too long");
	a_jtag_ready_pulse: assert property (jtag_ready |=> !jtag_ready) else $error("jtag ready too long");
	a_fab_data_hold: assert property (!fabric_ready |-> $stable(fabric_rdata)) else $error("fabric data moved");
	a_unused_reads_zero: assert property (j_unused_read |-> ##[4:7] (jtag_ready && jtag_rdata == UNUSED_READ))
		else $error("unused location not zero");
	a_status_write_done: assert property (f_status_write |-> f_answer) else $error("status write not answered");
	a_reset_quiet: assert property (disable iff (1'b0)
		rst |=> !fabric_ready && !jtag_ready && jtag_rdata == 16'h0000) else $error("port busy in reset");
endmodule
bind adc_status_register_map adc_status_register_map_assertions u_chk (.clk(clk), .rst(rst),
	.fabric_req(fabric_req), .fabric_rdata(fabric_rdata), .fabric_ready(fabric_ready), .jtag_req(jtag_req),
	.jtag_rdata(jtag_rdata), .jtag_ready(jtag_ready), .conv_result(conv_result), .coeff_update(coeff_update));

// ===== tb_adc_status_register_map.sv
// self-checking bench for the monitor register bank
`timescale 1ns/1ps
module tb_adc_status_register_map
	import monitor_regs_pkg::*;
;
	logic clk, rst;
	logic go [2];
	logic busy [2];
	logic rdy [2];
	logic [15:0] rd [2];
	port_req_t cmd [2];
	port_req_t rq [2];
	result_t conv_result;
	coeff_t coeff_update;
	logic [15:0] m [0:127];
	logic [15:0] q [2][$];
	logic [15:0] e, d;
	int num_errors, checked, cyc, seed;

	adc_status_register_map u_adc_status_register_map (.clk(clk), .rst(rst), .fabric_req(rq[0]),
		.fabric_rdata(rd[0]), .fabric_ready(rdy[0]), .jtag_req(rq[1]), .jtag_rdata(rd[1]), .jtag_ready(rdy[1]),
		.conv_result(conv_result), .coeff_update(coeff_update));
	port_master u_fabric_master (.clk(clk), .go(go[0]), .cmd(cmd[0]), .req(rq[0]), .ready(rdy[0]), .busy(busy[0]));
	port_master u_jtag_master (.clk(clk), .go(go[1]), .cmd(cmd[1]), .req(rq[1]), .ready(rdy[1]), .busy(busy[1]));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("errors %0d, checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// an all-unknown note means the old value cannot be known
	task automatic acc(input int j, input logic we, input logic [6:0] a, input logic [15:0] wd, input logic [15:0] x);
		q[j].push_back(x);
		cmd[j] = '{1'b1, we, a, wd};
		go[j] = 1'b1;
		@(negedge clk);
		go[j] = 1'b0;
		wait (!busy[j]);
		@(negedge clk);
	endtask
	task automatic rd_all(input int lo, input int hi);
		for (int a = lo; a <= hi; a++) acc(a % 2, 1'b0, 7'(a), 16'h0000, m[a]);
	endtask
	task automatic conv(input int ch, input logic [11:0] c);
		int pk;
		pk = (ch == 6) ? 35 : 32 + ch;
		// valid stays up between back-to-back results; the caller drops it
		conv_result = '{1'b1, 5'(ch), c};
		@(negedge clk);
		m[ch] = {c, LOW_PAD};
		if (ch inside {0, 1, 2, 6} && m[ch] > m[pk]) m[pk] = m[ch];
		if (ch == 0 && m[ch] < m[36]) m[36] = m[ch];
	endtask
	task automatic reset_all();
		rst = 1'b1;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		// control words survive reset, so only the status half is preset
		for (int i = 0; i < 64; i++) m[i] = (i == 36) ? LOWEST_RESET : 16'h0000;
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		#1;
		for (int j = 0; j < 2; j++) begin
			if (rdy[j] === 1'b1) begin
				e = q[j].pop_front();
				if (e !== 16'hXXXX) check(rd[j], e);
			end
		end
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		seed = 53671;
		num_errors = 0;
		checked = 0;
		cyc = 0;
		go = '{1'b0, 1'b0};
		cmd = '{'0, '0};
		conv_result = '0;
		coeff_update = '0;
		reset_all();
		rd_all(32, 36);
		for (int p = 0; p < 2; p++) begin
			// channels 7..0Ch carry no result
			for (int c = 0; c < 32; c++) if (!(c inside {[7:12]})) conv(c, 12'($random(seed)));
			conv_result.valid = 1'b0;
			for (int i = 0; i < 4; i++) begin
				coeff_update = '{1'b1, 2'(i), 16'($random(seed))};
				if (i < 3) m[8 + i] = coeff_update.value;
				@(negedge clk);
			end
			coeff_update.valid = 1'b0;
			rd_all(0, 36);
		end
		acc(0, 1'b1, 7'h00, 16'($random(seed)), m[0]);
		acc(1, 1'b1, 7'h20, 16'($random(seed)), m[32]);
		rd_all(31, 32);
		for (int a = 64; a < 128; a++) begin
			d = 16'($random(seed));
			acc(a % 2, 1'b1, 7'(a), d, m[a]);
			m[a] = d;
			acc(1 - a % 2, 1'b0, 7'(a), 16'h0000, m[a]);
		end
		// both sides pending at once; the write answers with the word it replaces
		fork
			acc(0, 1'b1, 7'h40, 16'h1234, m[64]);
			acc(1, 1'b0, 7'h7F, 16'h0000, m[127]);
		join
		m[64] = 16'h1234;
		acc(1, 1'b0, 7'h40, 16'h0000, m[64]);
		reset_all();
		rd_all(0, 36);
		summarize();
	end
endmodule
